// >>> clock_guard_map.svh
`ifndef CLOCK_GUARD_MAP_SVH
`define CLOCK_GUARD_MAP_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CONV_OSC_CTRL_ADDR 8'h00_D1
`define OSC_DIV_CTRL_ADDR 8'h00_DC
`define STATUS_ADDR 8'h00_DE
`define OSC_DIV_CTRL_RESET 8'h00_00
`define CONV_OSC_CTRL_RESET 8'h00_40
`define MAIN_OSC_DISABLE_BIT 2
`define DIV_SEL_LSB 0
`define DIV_SEL_MSB 1
`define OSC_DIV_USED_MASK 8'h00_0F

// ----------------------------------------
// timing
// ----------------------------------------
`define MIN_GAP_CYCLES 4'h0_2
`define MISS_LIMIT 8'h00_10
`define BACKUP_HALF_PERIOD 8'h00_08
`define RESET_DELAY_CYCLES 16'h0_040
`define STOP_RESTART_CYCLES 8'h00_01

`endif

// >>> clock_guard_pkg.sv
package clock_guard_pkg;
    typedef enum logic [3:0] {
        ST_HOLD = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_RUN = 4'b0100,
        ST_PIN = 4'b1000
    } reset_state_t;

    typedef enum logic [1:0] {
        SRC_MAIN = 2'b01,
        SRC_BACKUP = 2'b10
    } clk_src_t;
endpackage

// >>> reset_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "clock_guard_map.svh"

module reset_sync (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    logic next_stage1;
    logic next_sync;

    always_comb begin
        next_stage1 = async_in;
        next_sync = stage1;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync;
        end
    end
endmodule

`default_nettype wire

// >>> clock_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "clock_guard_map.svh"

module clock_divider (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic tick_in,
    input wire logic [1:0] div_sel_in,
    output logic tick_out
);
    logic [1:0] count;
    logic [1:0] next_count;
    logic next_tick;
    logic [1:0] limit;

    function automatic logic [1:0] div_limit(input logic [1:0] sel);
        begin
            if (sel == 2'b00) begin
                div_limit = 2'd0;
            end else if (sel == 2'b01) begin
                div_limit = 2'd1;
            end else begin
                div_limit = 2'd3;
            end
        end
    endfunction

    always_comb begin
        limit = div_limit(div_sel_in);
        next_count = count;
        next_tick = 1'b0;
        if (tick_in) begin
            if (count >= limit) begin
                next_count = 2'd0;
                next_tick = 1'b1;
            end else begin
                next_count = count + 2'd1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            count <= 2'd0;
            tick_out <= 1'b0;
        end else begin
            count <= next_count;
            tick_out <= next_tick;
        end
    end
endmodule

`default_nettype wire

// >>> clock_guard_and_reset_control.sv
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "clock_guard_map.svh"

module clock_guard_and_reset_control (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic guard_enable_in,
    input wire logic main_osc_edge_in,
    input wire logic reset_pin_in,
    input wire logic power_on_in,
    input wire logic watchdog_timeout_in,
    input wire logic undervoltage_in,
    input wire logic stop_mode_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic internal_reset_out,
    output logic io_pullup_out,
    output logic watchdog_reload_out,
    output logic reset_pin_out,
    output logic reset_pin_oe_out,
    output logic main_osc_enable_out,
    output logic backup_osc_enable_out,
    output logic clock_tick_out,
    output logic backup_active_out
);
    // ----------------------------------------
    // registers and bus
    // ----------------------------------------
    logic [7:0] conv_osc_ctrl;
    logic [7:0] osc_div_ctrl;
    logic [7:0] next_conv_osc_ctrl;
    logic [7:0] next_osc_div_ctrl;
    logic [7:0] next_rdata;
    logic pin_sync;
    logic pin_low;
    logic div_tick;

    reset_sync u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .async_in(reset_pin_in),
        .sync_out(pin_sync)
    );
    assign pin_low = !pin_sync;

    always_comb begin
        next_conv_osc_ctrl = conv_osc_ctrl;
        next_osc_div_ctrl = osc_div_ctrl;
        next_rdata = 8'h00_00;
        if (internal_reset_out) begin
            next_conv_osc_ctrl = `CONV_OSC_CTRL_RESET;
            next_osc_div_ctrl = `OSC_DIV_CTRL_RESET;
        end else if (wr_in) begin
            if (addr_in == `CONV_OSC_CTRL_ADDR) begin
                next_conv_osc_ctrl = wdata_in;
            end else if (addr_in == `OSC_DIV_CTRL_ADDR) begin
                next_osc_div_ctrl = wdata_in & `OSC_DIV_USED_MASK;
            end
        end
        if (rd_in) begin
            if (addr_in == `CONV_OSC_CTRL_ADDR) begin
                next_rdata = conv_osc_ctrl;
            end else if (addr_in == `STATUS_ADDR) begin
                next_rdata = {5'd0, backup_active_out, main_osc_enable_out,
                              internal_reset_out};
            end
            // divider control is write-only and reads zero
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            conv_osc_ctrl <= `CONV_OSC_CTRL_RESET;
            osc_div_ctrl <= `OSC_DIV_CTRL_RESET;
            rdata_out <= 8'h00_00;
        end else begin
            conv_osc_ctrl <= next_conv_osc_ctrl;
            osc_div_ctrl <= next_osc_div_ctrl;
            rdata_out <= next_rdata;
        end
    end

    // ----------------------------------------
    // oscillator guard and source select
    // ----------------------------------------
    logic main_disable;
    logic [3:0] gap;
    logic [3:0] next_gap;
    logic [7:0] miss;
    logic [7:0] next_miss;
    logic [7:0] bk_count;
    logic [7:0] next_bk_count;
    logic bk_phase;
    logic next_bk_phase;
    logic main_running;
    logic next_main_running;
    logic backup_tick;
    logic main_tick;
    logic src_tick;
    clock_guard_pkg::clk_src_t src;
    clock_guard_pkg::clk_src_t next_src;
    logic next_backup_active;
    logic next_main_en;
    logic next_backup_en;
    logic next_clock_tick;

    assign main_disable = conv_osc_ctrl[`MAIN_OSC_DISABLE_BIT]
        && guard_enable_in;

    always_comb begin
        next_gap = gap;
        next_miss = miss;
        next_main_running = main_running;
        main_tick = 1'b0;
        if (gap != 4'h0_0) begin
            next_gap = gap - 4'h0_1;
        end
        if (main_osc_edge_in && !main_disable) begin
            next_miss = 8'h00_00;
            next_main_running = 1'b1;
            if (!guard_enable_in || gap == 4'h0_0) begin
                main_tick = 1'b1;
                next_gap = `MIN_GAP_CYCLES;
            end
        end else if (miss != `MISS_LIMIT) begin
            next_miss = miss + 8'h00_01;
        end else begin
            next_main_running = 1'b0;
        end
        if (main_disable) begin
            next_main_running = 1'b0;
        end
    end

    always_comb begin
        next_bk_count = bk_count;
        next_bk_phase = bk_phase;
        backup_tick = 1'b0;
        next_src = src;
        if (backup_active_out) begin
            if (bk_count == `BACKUP_HALF_PERIOD) begin
                next_bk_count = 8'h00_00;
                next_bk_phase = !bk_phase;
                backup_tick = bk_phase;
            end else begin
                next_bk_count = bk_count + 8'h00_01;
            end
        end else begin
            next_bk_count = 8'h00_00;
            next_bk_phase = 1'b0;
        end
        // switch to backup at once; switch back to main on a whole backup pulse boundary (backup_tick), or at once when the guard is off
        if (guard_enable_in && !main_running && src == clock_guard_pkg::SRC_MAIN) begin
            next_src = clock_guard_pkg::SRC_BACKUP;
        end else if (main_running && src == clock_guard_pkg::SRC_BACKUP && backup_tick) begin
            next_src = clock_guard_pkg::SRC_MAIN;
        end else if (!guard_enable_in) begin
            next_src = clock_guard_pkg::SRC_MAIN;
        end
        src_tick = (src == clock_guard_pkg::SRC_MAIN) ? main_tick : backup_tick;
        next_backup_active = guard_enable_in
            && (next_src == clock_guard_pkg::SRC_BACKUP);
        next_backup_en = next_backup_active;
        next_main_en = !main_disable;
    end

    clock_divider u_div (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .tick_in(src_tick),
        .div_sel_in(osc_div_ctrl[`DIV_SEL_MSB:`DIV_SEL_LSB]),
        .tick_out(div_tick)
    );
    assign next_clock_tick = div_tick && !internal_reset_out;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            gap <= 4'h0_0;
            miss <= 8'h00_00;
            main_running <= 1'b0;
            bk_count <= 8'h00_00;
            bk_phase <= 1'b0;
            src <= clock_guard_pkg::SRC_MAIN;
            backup_active_out <= 1'b0;
            main_osc_enable_out <= 1'b1;
            backup_osc_enable_out <= 1'b0;
            clock_tick_out <= 1'b0;
        end else begin
            gap <= next_gap;
            miss <= next_miss;
            main_running <= next_main_running;
            bk_count <= next_bk_count;
            bk_phase <= next_bk_phase;
            src <= next_src;
            backup_active_out <= next_backup_active;
            main_osc_enable_out <= next_main_en;
            backup_osc_enable_out <= next_backup_en;
            clock_tick_out <= next_clock_tick;
        end
    end

    // ----------------------------------------
    // reset generation
    // ----------------------------------------
    clock_guard_pkg::reset_state_t rst_state;
    clock_guard_pkg::reset_state_t next_rst_state;
    logic [15:0] delay;
    logic [15:0] next_delay;
    logic internal_src;
    logic any_src;
    logic next_internal_reset;
    logic next_pullup;
    logic next_wd_reload;
    logic next_pin_drive;

    assign internal_src = power_on_in || watchdog_timeout_in || undervoltage_in;
    assign any_src = internal_src || pin_low;

    always_comb begin
        next_rst_state = rst_state;
        next_delay = delay;
        case (rst_state)
            clock_guard_pkg::ST_HOLD: begin
                next_delay = 16'h0_000;
                if (!any_src) begin
                    next_rst_state = clock_guard_pkg::ST_DELAY;
                end
            end
            clock_guard_pkg::ST_DELAY: begin
                if (any_src) begin
                    next_rst_state = clock_guard_pkg::ST_HOLD;
                end else if (src_tick) begin
                    // delay counts whichever source runs
                    if (delay == `RESET_DELAY_CYCLES) begin
                        next_rst_state = clock_guard_pkg::ST_RUN;
                    end else begin
                        next_delay = delay + 16'h0_001;
                    end
                end
            end
            clock_guard_pkg::ST_RUN: begin
                if (any_src) begin
                    next_rst_state = clock_guard_pkg::ST_HOLD;
                end
            end
            clock_guard_pkg::ST_PIN: begin
                next_rst_state = clock_guard_pkg::ST_HOLD;
            end
            default: begin
                next_rst_state = clock_guard_pkg::ST_HOLD;
            end
        endcase
        next_internal_reset = (next_rst_state != clock_guard_pkg::ST_RUN);
        next_pullup = next_internal_reset;
        next_wd_reload = watchdog_timeout_in || next_internal_reset;
        next_pin_drive = internal_src;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            rst_state <= clock_guard_pkg::ST_HOLD;
            delay <= 16'h0_000;
            internal_reset_out <= 1'b1;
            io_pullup_out <= 1'b1;
            watchdog_reload_out <= 1'b1;
            reset_pin_out <= 1'b0;
            reset_pin_oe_out <= 1'b0;
        end else begin
            rst_state <= next_rst_state;
            delay <= next_delay;
            internal_reset_out <= next_internal_reset;
            io_pullup_out <= next_pullup;
            watchdog_reload_out <= next_wd_reload;
            reset_pin_out <= 1'b0;
            reset_pin_oe_out <= next_pin_drive;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_div_by_one: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (osc_div_ctrl[`DIV_SEL_MSB:`DIV_SEL_LSB] == 2'b00 && $stable(osc_div_ctrl)
         && src_tick) |=> div_tick)
        else $error("divide by one lost a tick");
    a_pin_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (!pin_sync) |=> internal_reset_out)
        else $error("reset not held while pin low");
    a_internal_drive: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        internal_src |=> reset_pin_oe_out && !reset_pin_out)
        else $error("reset pin not driven low");
    a_guard_off: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        !guard_enable_in |=> !backup_active_out)
        else $error("backup active without guard");
    a_pullup_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        any_src |=> io_pullup_out && internal_reset_out)
        else $error("pullups missing in reset");
    a_spike_drop: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (main_tick && guard_enable_in) |=> !main_tick)
        else $error("spike passed guard");
    a_osc_off: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (main_disable && !internal_reset_out) |=> !main_osc_enable_out)
        else $error("main oscillator not stopped");
    a_wd_reload: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        watchdog_timeout_in |=> watchdog_reload_out && internal_reset_out)
        else $error("watchdog reset missing");
    c_backup_on: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        $rose(backup_active_out));
    c_back_main: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        $fell(backup_active_out));
    c_release: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        $fell(internal_reset_out));
endmodule

`default_nettype wire

// >>> osc_partner.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// crystal and board reset circuit
// ----------------------------------------
module osc_partner (
    input wire logic sys_clk_in,
    input wire logic osc_enable_in,
    input wire logic crystal_ok_in,
    input wire logic [3:0] spacing_in,
    input wire logic board_reset_b_in,
    input wire logic pin_drive_in,
    input wire logic pin_oe_in,
    output logic main_osc_edge_out,
    output logic reset_pin_out
);
    logic [3:0] count = 4'h0;

    initial main_osc_edge_out = 1'b0;

    // edges only while the crystal works and the device lets it run
    always @(posedge sys_clk_in) begin
        if (!(osc_enable_in && crystal_ok_in)) begin
            count <= 4'h0;
            main_osc_edge_out <= 1'b0;
        end else if (count + 4'h1 >= spacing_in) begin
            count <= 4'h0;
            main_osc_edge_out <= 1'b1;
        end else begin
            count <= count + 4'h1;
            main_osc_edge_out <= 1'b0;
        end
    end

    // pulled-up pin, low when the board or the device pulls it
    assign reset_pin_out = board_reset_b_in & ~(pin_oe_in & ~pin_drive_in);
endmodule

`default_nettype wire

// >>> clock_guard_and_reset_control_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "clock_guard_map.svh"

module clock_guard_and_reset_control_test;
    logic sys_clk_in = 1'b0, rst_b_in = 1'b0, guard_en = 1'b1, stop_mode = 1'b0;
    logic wdog = 1'b0, por = 1'b0, uv = 1'b0, board_b = 1'b1, crystal = 1'b0;
    logic wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, shadow = 8'h00;
    logic [3:0] spacing = 4'h4;
    logic [7:0] rdata;
    logic osc_edge, pin_level, internal_reset, io_pullup, reload, pin_drive, pin_oe;
    logic main_en, backup_en, tick, backup_act;
    int fail_count = 0;
    int checks = 0;

    clock_guard_and_reset_control DUT (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .guard_enable_in(guard_en),
        .main_osc_edge_in(osc_edge), .reset_pin_in(pin_level), .power_on_in(por),
        .watchdog_timeout_in(wdog), .undervoltage_in(uv), .stop_mode_in(stop_mode),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .internal_reset_out(internal_reset), .io_pullup_out(io_pullup),
        .watchdog_reload_out(reload), .reset_pin_out(pin_drive),
        .reset_pin_oe_out(pin_oe), .main_osc_enable_out(main_en),
        .backup_osc_enable_out(backup_en), .clock_tick_out(tick),
        .backup_active_out(backup_act)
    );

    osc_partner board (
        .sys_clk_in(sys_clk_in), .osc_enable_in(main_en), .crystal_ok_in(crystal),
        .spacing_in(spacing), .board_reset_b_in(board_b), .pin_drive_in(pin_drive),
        .pin_oe_in(pin_oe), .main_osc_edge_out(osc_edge), .reset_pin_out(pin_level)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    task close_out();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task step(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return internal_reset;
            1: return backup_act;
            default: return tick;
        endcase
    endfunction

    task wait_sig(input int sel, input logic want, input int limit, output int n);
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pick(sel) !== want && n < limit);
    endtask

    task tick_gap(output int n);
        wait_sig(2, 1'b1, 300, n);
        @(posedge sys_clk_in);
        n = 1;
        while (tick !== 1'b1 && n < 300) begin
            @(posedge sys_clk_in);
            n++;
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask

    task rd_check(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1;
        check(rdata, exp, msg);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_power_up();
        int n;
        wait_sig(0, 1'b0, 2000, n);
        check(internal_reset, 0, "no start on backup");
        check(backup_act, 1, "backup not running");
        check(io_pullup, 0, "pull-up stuck");
        rd_check(`STATUS_ADDR, 8'h06, "status after power-up");
        rd_check(`CONV_OSC_CTRL_ADDR, `CONV_OSC_CTRL_RESET, "control reset");
        rd_check(`OSC_DIV_CTRL_ADDR, 8'h00, "divider readable");
        rd_check(8'h10, 8'h00, "unmapped read");
        crystal <= 1'b1;
        wait_sig(1, 1'b0, 100, n);
        check(backup_act, 0, "backup kept");
        check(backup_en, 0, "backup enable kept");
    endtask

    task t_divider();
        int n;
        for (int c = 0; c < 4; c++) begin
            shadow = 8'(c); // ram copy first bits 3:2 zero
            wr_reg(`OSC_DIV_CTRL_ADDR, shadow);
            tick_gap(n);
            tick_gap(n);
            check(16'(n), 16'(4 << ((c > 1) ? 2 : c)), "divider gap");
        end
        rd_check(`OSC_DIV_CTRL_ADDR, 8'h00, "divider readable");
        shadow = 8'h00;
        wr_reg(`OSC_DIV_CTRL_ADDR, shadow);
    endtask

    task t_spike();
        int n;
        spacing <= 4'h1;
        tick_gap(n);
        tick_gap(n);
        check(16'(n >= 2 && n < 300), 1, "spike passed");
        spacing <= 4'h4;
        step(40);
    endtask

    task t_failover();
        int n;
        crystal <= 1'b0;
        wait_sig(1, 1'b1, 80, n);
        check(backup_act, 1, "no failover");
        tick_gap(n);
        tick_gap(n);
        check(16'(n), 16'd18, "backup gap");
        crystal <= 1'b1;
        wait_sig(1, 1'b0, 100, n);
        check(backup_act, 0, "backup kept");
    endtask

    task t_disable();
        int n;
        wr_reg(`CONV_OSC_CTRL_ADDR, 8'h44);
        step(2);
        check(main_en, 0, "main not stopped");
        wait_sig(1, 1'b1, 80, n);
        check(backup_act, 1, "backup not started");
        rd_check(`CONV_OSC_CTRL_ADDR, 8'h44, "control readback");
        wr_reg(`CONV_OSC_CTRL_ADDR, 8'h40);
        step(2);
        check(main_en, 1, "main not restarted");
        wait_sig(1, 1'b0, 100, n);
        check(backup_act, 0, "backup kept");
    endtask

    task t_guard_off();
        guard_en <= 1'b0;
        crystal <= 1'b0;
        wr_reg(`CONV_OSC_CTRL_ADDR, 8'h44);
        step(80);
        check(backup_act, 0, "backup without guard");
        check(main_en, 1, "stopped without guard");
        wr_reg(`CONV_OSC_CTRL_ADDR, 8'h40);
        crystal <= 1'b1;
        guard_en <= 1'b1;
        step(40);
    endtask

    task t_reset(input int code, input logic stop);
        int n;
        stop_mode <= stop;
        board_b <= (code != 0);
        por <= (code == 1);
        wdog <= (code == 2);
        uv <= (code == 3);
        @(posedge sys_clk_in);
        wdog <= 1'b0;
        board_b <= 1'b1;
        #1;
        if (code != 0) begin
            check(internal_reset, 1, "reset late");
            check(pin_oe, 1, "pin not pulled");
            check(pin_drive, 0, "pin driven high");
        end
        if (code == 2) check(reload, 1, "no reload");
        step(10);
        check(internal_reset, 1, "reset dropped");
        check(io_pullup, 1, "no pull-up");
        check(main_en, 1, "main held off");
        if (code == 0) check(pin_oe, 0, "pin driven");
        por <= 1'b0;
        uv <= 1'b0;
        wr_reg(`CONV_OSC_CTRL_ADDR, 8'h44);
        wait_sig(0, 1'b0, 400, n);
        check(16'(n >= 230 && n <= 330), 1, "delay off");
        rd_check(`CONV_OSC_CTRL_ADDR, `CONV_OSC_CTRL_RESET, "write in reset");
        stop_mode <= 1'b0;
    endtask

    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial begin
        #400000;
        fail_count++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        t_power_up();
        t_divider();
        t_spike();
        t_failover();
        t_disable();
        t_guard_off();
        for (int c = 0; c < 4; c++) t_reset(c, 1'b0);
        t_reset(0, 1'b1);
        close_out();
    end
endmodule

`default_nettype wire
